// File: logic/diag_record_pkg.sv
// constants and carriers for the analog input diagnostic record
// assumes the record is read byte by byte through a record-set select and byte index
// Operation
// - set system flag bit 4 on communication error
// - set system flag bit 6 on lost interrupt
// - channel kind byte reads 71h
// - report eight diagnostic bits per channel
// - report four channels present
// - group error bits 0-3, one per channel
// - channel fault bit 0 on parameter error
// - bit 4 open wire, RTD/TC mode only
// - bit 5 on channel interrupt lost
// - bit 6 on measuring range underflow
// - bit 7 on measuring range overflow
// - timestamp captures microsecond count at event
// - microsecond counter starts zero, counts per microsecond
// - counter wraps to zero after maximum
// - summary bit 3 channel error, bit 7 parameter error
`default_nettype none
package diag_record_pkg;
	localparam int          CLK_MHZ         = 100;
	localparam int          US_NS           = 1000;
	localparam int          CLK_NS          = 10;
	localparam int          US_CYCLES       = US_NS / CLK_NS;
	localparam logic [7:0]  SET_HEAD        = 8'h00;
	localparam logic [7:0]  SET_FULL        = 8'h01;
	localparam int          HEAD_BYTES      = 4;
	localparam int          RECORD_BYTES    = 20;
	// byte offsets within the record
	localparam logic [4:0]  OFS_SUMMARY     = 5'h00;
	localparam logic [4:0]  OFS_MODCLASS    = 5'h01;
	localparam logic [4:0]  OFS_SYSFLAG     = 5'h03;
	localparam logic [4:0]  OFS_KIND        = 5'h04;
	localparam logic [4:0]  OFS_NBITS       = 5'h05;
	localparam logic [4:0]  OFS_NCH         = 5'h06;
	localparam logic [4:0]  OFS_GROUP       = 5'h07;
	localparam logic [4:0]  OFS_CHAN0       = 5'h08;
	localparam logic [4:0]  OFS_STAMP       = 5'h10;
	// field positions
	localparam int          SYS_COMM_BIT    = 4;
	localparam int          SYS_LOST_BIT    = 6;
	localparam int          SUM_CHAN_BIT    = 3;
	localparam int          SUM_PARAM_BIT   = 7;
	localparam int          CF_PARAM_BIT    = 0;
	localparam int          CF_WIRE_BIT     = 4;
	localparam int          CF_LOST_BIT     = 5;
	localparam int          CF_UNDER_BIT    = 6;
	localparam int          CF_OVER_BIT     = 7;
	// constant bytes
	localparam logic [7:0]  KIND_ANALOG_IN  = 8'h71;
	localparam logic [7:0]  DIAG_BITS       = 8'h08;
	localparam logic [7:0]  CHAN_COUNT      = 8'h04;
	localparam logic [7:0]  MODCLASS_VALUE  = 8'h15;
	localparam logic [31:0] STAMP_RESET     = 32'h0000_0000;

	typedef enum logic [1:0] {
		MODE_VOLT_CUR = 2'h0,
		MODE_RES      = 2'h1,
		MODE_RTD      = 2'h2,
		MODE_TC       = 2'h3
	} chan_mode_t;

	// per-channel fault conditions reported by the measurement side
	typedef struct packed {
		logic       paramErr;
		logic       openWire;
		logic       intrLost;
		logic       underRange;
		logic       overRange;
		chan_mode_t mode;
	} chan_cond_t;

	typedef struct packed {
		logic [4:0] index;
		logic [7:0] set;
	} rd_req_t;
endpackage
`default_nettype wire

// File: logic/us_ticker.sv
// free running microsecond counter
// assumes ref_clk at the rate in the package; wraps silently at full scale
`timescale 1ns/1ns
`default_nettype none
module us_ticker
	import diag_record_pkg::*;
#(
	parameter int DIV = US_CYCLES
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// count
	output logic [31:0]      count
);
	initial begin
		if (DIV < 1 || DIV > 65535) $error("us_ticker: bad divider");
	end

	typedef struct packed {
		logic [15:0] div;
		logic [31:0] cnt;
	} tick_state_t;

	tick_state_t st;
	tick_state_t next_st;

	always_comb begin
		next_st = st;
		if (st.div == 16'(DIV - 1)) begin
			next_st.div = 16'h0000;
			next_st.cnt = st.cnt + 32'h0000_0001;
		end else begin
			next_st.div = st.div + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign count = st.cnt;

	property p_tick_rate;
		@(posedge ref_clk) disable iff (sys_rst)
		(st.div == 16'(DIV - 1)) |=> (st.cnt == $past(st.cnt) + 32'h0000_0001);
	endproperty
	a_tick_rate: assert property (p_tick_rate) else $error("tick did not advance");

	property p_tick_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		(st.div != 16'(DIV - 1)) |=> $stable(st.cnt);
	endproperty
	a_tick_hold: assert property (p_tick_hold) else $error("count moved between ticks");
endmodule
`default_nettype wire

// File: logic/analog_input_diag_record.sv
// diagnostic record of a four channel analog input module
// assumes condition inputs are synchronous to ref_clk; read index and set come from same-clock logic
`timescale 1ns/1ns
`default_nettype none
module analog_input_diag_record
	import diag_record_pkg::*;
#(
	parameter int NCH = 4
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	// module level events
	input  wire logic              commErr,
	input  wire logic              intrLostAny,
	// channel conditions
	input  wire chan_cond_t        chanCond [NCH],
	// record read port
	input  wire logic              rdStrobe,
	input  wire rd_req_t           rdReq,
	output logic                   rdValid,
	output logic                   rdError,
	output logic [7:0]             rdData,
	// raised diagnostic
	output logic                   diagEvent
);
	initial begin
		if (NCH != 4) $error("analog_input_diag_record: four channels only");
	end

	typedef struct packed {
		logic [7:0]  sysFlag;
		logic [7:0]  summary;
		logic [7:0]  group;
		logic [31:0] stamp;
		logic [NCH*8-1:0] chanFlags;
		logic        valid;
		logic        error;
		logic [7:0]  data;
		logic        event_;
	} rec_state_t;

	rec_state_t     st;
	rec_state_t     next_st;
	logic [31:0]    usCount;
	logic [7:0]     chanByte [NCH];
	logic [NCH-1:0] chanAny;
	logic [NCH-1:0] wireAllowed;

	us_ticker #(
		.DIV(US_CYCLES)
	) u_ticker (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.count  (usCount)
	);

	// fault bytes are live images of the channel conditions
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_chan
			assign wireAllowed[g] = (chanCond[g].mode == MODE_RTD) || (chanCond[g].mode == MODE_TC);
			always_comb begin
				chanByte[g]               = 8'h00;
				chanByte[g][CF_PARAM_BIT] = chanCond[g].paramErr;
				chanByte[g][CF_WIRE_BIT]  = chanCond[g].openWire && wireAllowed[g];
				chanByte[g][CF_LOST_BIT]  = chanCond[g].intrLost;
				chanByte[g][CF_UNDER_BIT] = chanCond[g].underRange;
				chanByte[g][CF_OVER_BIT]  = chanCond[g].overRange;
			end
			assign chanAny[g] = |chanByte[g];
		end
	endgenerate

	logic [7:0]        next_sys;
	logic [7:0]        next_group;
	logic [7:0]        next_sum;
	logic [NCH*8-1:0]  next_flags;
	logic              anyParam;

	always_comb begin
		next_sys                = 8'h00;
		next_sys[SYS_COMM_BIT]  = commErr;
		next_sys[SYS_LOST_BIT]  = intrLostAny;
		next_group              = 8'h00;
		next_group[NCH-1:0]     = chanAny;
		anyParam                = 1'b0;
		next_flags              = '0;
		for (int i = 0; i < NCH; i++) begin
			next_flags[i*8 +: 8] = chanByte[i];
			anyParam             = anyParam | chanByte[i][CF_PARAM_BIT];
		end
		next_sum                = 8'h00;
		next_sum[SUM_CHAN_BIT]  = |chanAny;
		next_sum[SUM_PARAM_BIT] = anyParam;
	end

	// a diagnostic is raised when any reported flag newly rises
	logic rising;
	assign rising = |({next_sys, next_group, next_sum, next_flags} & ~{st.sysFlag, st.group, st.summary, st.chanFlags});

	function automatic logic [7:0] read_byte(input rec_state_t s, input logic [4:0] idx);
		logic [7:0] b;
		b = 8'h00;
		if (idx == OFS_SUMMARY) begin
			b = s.summary;
		end else if (idx == OFS_MODCLASS) begin
			b = MODCLASS_VALUE;
		end else if (idx == OFS_SYSFLAG) begin
			b = s.sysFlag;
		end else if (idx == OFS_KIND) begin
			b = KIND_ANALOG_IN;
		end else if (idx == OFS_NBITS) begin
			b = DIAG_BITS;
		end else if (idx == OFS_NCH) begin
			b = CHAN_COUNT;
		end else if (idx == OFS_GROUP) begin
			b = s.group;
		end else if (idx >= OFS_CHAN0 && idx < OFS_CHAN0 + 5'(NCH)) begin
			b = s.chanFlags[(idx - OFS_CHAN0) * 8 +: 8];
		end else if (idx >= OFS_STAMP) begin
			b = s.stamp[(idx - OFS_STAMP) * 8 +: 8];
		end
		return b;
	endfunction

	logic inRange;
	always_comb begin
		// head set serves only the first four bytes; full set serves the whole record
		if (rdReq.set == SET_FULL) begin
			inRange = rdReq.index < 5'(RECORD_BYTES);
		end else if (rdReq.set == SET_HEAD) begin
			inRange = rdReq.index < 5'(HEAD_BYTES);
		end else begin
			inRange = 1'b0;
		end
	end

	always_comb begin
		next_st           = st;
		next_st.sysFlag   = next_sys;
		next_st.group     = next_group;
		next_st.summary   = next_sum;
		next_st.chanFlags = next_flags;
		next_st.event_    = rising;
		if (rising) begin
			next_st.stamp = usCount;
		end
		next_st.valid = rdStrobe && inRange;
		next_st.error = rdStrobe && !inRange;
		next_st.data  = (rdStrobe && inRange) ? read_byte(st, rdReq.index) : 8'h00;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rdValid   = st.valid;
	assign rdError   = st.error;
	assign rdData    = st.data;
	assign diagEvent = st.event_;

	property p_comm_flag;
		@(posedge ref_clk) disable iff (sys_rst)
		commErr |=> st.sysFlag[SYS_COMM_BIT];
	endproperty
	a_comm_flag: assert property (p_comm_flag) else $error("comm flag missing");

	property p_lost_flag;
		@(posedge ref_clk) disable iff (sys_rst)
		intrLostAny |=> st.sysFlag[SYS_LOST_BIT] && !st.sysFlag[5] && !st.sysFlag[7];
	endproperty
	a_lost_flag: assert property (p_lost_flag) else $error("lost flag missing");

	property p_kind_read;
		@(posedge ref_clk) disable iff (sys_rst)
		(rdStrobe && rdReq.set == SET_FULL && rdReq.index == OFS_KIND) |=> rdValid && rdData == 8'h71;
	endproperty
	a_kind_read: assert property (p_kind_read) else $error("kind byte wrong");

	property p_nbits_read;
		@(posedge ref_clk) disable iff (sys_rst)
		(rdStrobe && rdReq.set == SET_FULL && rdReq.index == OFS_NBITS) |=> rdData == 8'h08;
	endproperty
	a_nbits_read: assert property (p_nbits_read) else $error("bit count wrong");

	property p_nch_read;
		@(posedge ref_clk) disable iff (sys_rst)
		(rdStrobe && rdReq.set == SET_FULL && rdReq.index == OFS_NCH) |=> rdData == 8'h04;
	endproperty
	a_nch_read: assert property (p_nch_read) else $error("channel count wrong");

	property p_wire_mode;
		@(posedge ref_clk) disable iff (sys_rst)
		(chanCond[1].openWire && chanCond[1].mode != MODE_RTD && chanCond[1].mode != MODE_TC)
			|=> !st.chanFlags[8 + CF_WIRE_BIT];
	endproperty
	a_wire_mode: assert property (p_wire_mode) else $error("open wire outside RTD/TC");

	property p_group_follows;
		@(posedge ref_clk) disable iff (sys_rst)
		1'b1 |=> st.group[0] == $past(chanCond[0].paramErr || chanCond[0].intrLost || chanCond[0].underRange
			|| chanCond[0].overRange || (chanCond[0].openWire && chanCond[0].mode inside {MODE_RTD, MODE_TC}));
	endproperty
	a_group_follows: assert property (p_group_follows) else $error("group bit mismatch");

	property p_stamp_capture;
		@(posedge ref_clk) disable iff (sys_rst)
		rising |=> diagEvent && st.stamp == $past(usCount);
	endproperty
	a_stamp_capture: assert property (p_stamp_capture) else $error("stamp not captured");

	property p_head_limit;
		@(posedge ref_clk) disable iff (sys_rst)
		(rdStrobe && rdReq.set == SET_HEAD && rdReq.index >= 5'(HEAD_BYTES)) |=> rdError && !rdValid;
	endproperty
	a_head_limit: assert property (p_head_limit) else $error("head set overran");

	property p_summary;
		@(posedge ref_clk) disable iff (sys_rst)
		chanCond[0].paramErr |=> st.summary[SUM_PARAM_BIT] && st.summary[SUM_CHAN_BIT];
	endproperty
	a_summary: assert property (p_summary) else $error("summary flags wrong");

	property p_param_bit;
		@(posedge ref_clk) disable iff (sys_rst)
		chanCond[0].paramErr |=> st.chanFlags[CF_PARAM_BIT];
	endproperty
	a_param_bit: assert property (p_param_bit) else $error("parameter fault bit missing");

	property p_wire_rtd;
		@(posedge ref_clk) disable iff (sys_rst)
		(chanCond[1].openWire && chanCond[1].mode == MODE_RTD) |=> st.chanFlags[8 + CF_WIRE_BIT];
	endproperty
	a_wire_rtd: assert property (p_wire_rtd) else $error("open wire missing in RTD mode");

	property p_wire_tc;
		@(posedge ref_clk) disable iff (sys_rst)
		(chanCond[1].openWire && chanCond[1].mode == MODE_TC) |=> st.chanFlags[8 + CF_WIRE_BIT];
	endproperty
	a_wire_tc: assert property (p_wire_tc) else $error("open wire missing in TC mode");

	property p_lost_bit;
		@(posedge ref_clk) disable iff (sys_rst)
		chanCond[1].intrLost |=> st.chanFlags[8 + CF_LOST_BIT];
	endproperty
	a_lost_bit: assert property (p_lost_bit) else $error("channel lost bit missing");

	property p_under_bit;
		@(posedge ref_clk) disable iff (sys_rst)
		chanCond[2].underRange |=> st.chanFlags[16 + CF_UNDER_BIT];
	endproperty
	a_under_bit: assert property (p_under_bit) else $error("underflow bit missing");

	property p_over_bit;
		@(posedge ref_clk) disable iff (sys_rst)
		chanCond[3].overRange |=> st.chanFlags[24 + CF_OVER_BIT];
	endproperty
	a_over_bit: assert property (p_over_bit) else $error("overflow bit missing");

	property p_group_any;
		@(posedge ref_clk) disable iff (sys_rst)
		chanCond[3].overRange |=> st.group[3];
	endproperty
	a_group_any: assert property (p_group_any) else $error("group bit 3 missing");

	property p_comm_clear;
		@(posedge ref_clk) disable iff (sys_rst)
		!commErr |=> !st.sysFlag[SYS_COMM_BIT];
	endproperty
	a_comm_clear: assert property (p_comm_clear) else $error("comm flag stuck");

	property p_chan_summary;
		@(posedge ref_clk) disable iff (sys_rst)
		chanCond[2].underRange |=> st.summary[SUM_CHAN_BIT];
	endproperty
	a_chan_summary: assert property (p_chan_summary) else $error("summary channel bit missing");

	property p_stamp_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		!rising |=> $stable(st.stamp);
	endproperty
	a_stamp_hold: assert property (p_stamp_hold) else $error("stamp moved without event");

	property p_event_pulse;
		@(posedge ref_clk) disable iff (sys_rst)
		!rising |=> !diagEvent;
	endproperty
	a_event_pulse: assert property (p_event_pulse) else $error("event without new flag");

	property p_refused_data;
		@(posedge ref_clk) disable iff (sys_rst)
		(rdStrobe && !inRange) |=> rdError && !rdValid && rdData == 8'h00;
	endproperty
	a_refused_data: assert property (p_refused_data) else $error("refused read not flagged");

	property p_set_invalid;
		@(posedge ref_clk) disable iff (sys_rst)
		(rdStrobe && rdReq.set != SET_HEAD && rdReq.set != SET_FULL) |=> rdError && !rdValid;
	endproperty
	a_set_invalid: assert property (p_set_invalid) else $error("unknown set answered");

	property p_stamp_byte;
		@(posedge ref_clk) disable iff (sys_rst)
		(rdStrobe && rdReq.set == SET_FULL && rdReq.index == OFS_STAMP) |=> rdValid && rdData == $past(st.stamp[7:0]);
	endproperty
	a_stamp_byte: assert property (p_stamp_byte) else $error("stamp low byte wrong");
endmodule
`default_nettype wire

// File: verif/record_reader.sv
// controller model that reads the diagnostic record one byte per request
// assumes requests launch 1 ns after the rising edge of ref_clk
`timescale 1ns/1ns
`default_nettype none
module record_reader
	import diag_record_pkg::*;
(
	// clock
	input  wire logic       ref_clk,
	// record read port
	input  wire logic       rdValid,
	input  wire logic       rdError,
	input  wire logic [7:0] rdData,
	output var rd_req_t     rdReq,
	output logic            rdStrobe
);
	initial begin
		rdStrobe = 1'b0;
		rdReq = '{index: 5'h1F, set: 8'hFF};
	end
	// answer is taken 1 ns after the taking edge, then the request drops
	task automatic rd(input logic [7:0] set, input logic [4:0] index, output logic ok, output logic bad,
		output logic [7:0] data);
		@(posedge ref_clk);
		#1;
		rdStrobe = 1'b1;
		rdReq = '{index: index, set: set};
		@(posedge ref_clk);
		#1;
		ok = rdValid;
		bad = rdError;
		data = rdData;
		rdStrobe = 1'b0;
		// released request shows the inverse so a stale value cannot pass
		rdReq = '{index: ~index, set: ~set};
	endtask
endmodule
`default_nettype wire

// File: verif/tb_analog_input_diag_record.sv
// self-checking bench for the diagnostic record
// assumes a 100 MHz ref_clk and the record_reader model on the read port
`timescale 1ns/1ns
`default_nettype none
module tb_analog_input_diag_record;
	import diag_record_pkg::*;
	logic            ref_clk;
	logic            sys_rst;
	logic            commErr;
	logic            intrLostAny;
	chan_cond_t      chanCond [4];
	logic            rdStrobe;
	rd_req_t         rdReq;
	logic            rdValid;
	logic            rdError;
	logic [7:0]      rdData;
	logic            diagEvent;
	int              miscompares = 0;
	int              checks_done = 0;

	analog_input_diag_record dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .commErr(commErr),
		.intrLostAny(intrLostAny), .chanCond(chanCond), .rdStrobe(rdStrobe), .rdReq(rdReq),
		.rdValid(rdValid), .rdError(rdError), .rdData(rdData), .diagEvent(diagEvent));
	record_reader host (.ref_clk(ref_clk), .rdValid(rdValid), .rdError(rdError), .rdData(rdData),
		.rdReq(rdReq), .rdStrobe(rdStrobe));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic expect_byte(input logic [7:0] set, input logic [4:0] idx, input logic [7:0] exp);
		logic ok, bad;
		logic [7:0] d;
		host.rd(set, idx, ok, bad, d);
		chk($sformatf("valid %h/%h", set, idx), 32'h1, {31'h0, ok & ~bad});
		chk($sformatf("byte %h/%h", set, idx), {24'h0, exp}, {24'h0, d});
	endtask

	task automatic refuse(input logic [7:0] set, input logic [4:0] idx);
		logic ok, bad;
		logic [7:0] d;
		host.rd(set, idx, ok, bad, d);
		chk("refused flags", 32'h1, {30'h0, ok, bad});
		chk("refused data", 32'h0, {24'h0, d});
	endtask

	task automatic expect_stamp(input logic [31:0] exp);
		for (int i = 0; i < 4; i++) begin
			expect_byte(SET_FULL, 5'(OFS_STAMP + i), exp[8*i +: 8]);
		end
	endtask

	task automatic t_constants();
		expect_byte(SET_FULL, OFS_KIND, 8'h71);
		expect_byte(SET_FULL, OFS_NBITS, 8'h08);
		expect_byte(SET_FULL, OFS_NCH, 8'h04);
		expect_byte(SET_HEAD, OFS_SYSFLAG, 8'h00);
		expect_byte(SET_FULL, 5'h0C, 8'h00);
		expect_byte(SET_HEAD, OFS_MODCLASS, 8'h15);
		expect_byte(SET_HEAD, 5'h02, 8'h00);
		expect_byte(SET_HEAD, OFS_SUMMARY, 8'h00);
		chk("idle event", 32'h0, {31'h0, diagEvent});
	endtask

	task automatic t_refuse();
		refuse(8'h02, 5'h00);
		refuse(SET_HEAD, 5'h04);
		refuse(SET_FULL, 5'h14);
		expect_byte(SET_FULL, 5'h13, 8'h00);
	endtask

	task automatic t_sysflags();
		commErr = 1'b1;
		tick(1);
		expect_byte(SET_HEAD, OFS_SYSFLAG, 8'h10);
		commErr = 1'b0;
		intrLostAny = 1'b1;
		tick(1);
		expect_byte(SET_FULL, OFS_SYSFLAG, 8'h40);
		intrLostAny = 1'b0;
		tick(1);
		expect_byte(SET_FULL, OFS_SYSFLAG, 8'h00);
	endtask

	// each channel carries a different fault kind so a swapped bit or channel shows
	task automatic t_channels();
		logic [7:0] fexp [4] = '{8'h01, 8'h20, 8'h40, 8'h80};
		for (int c = 0; c < 4; c++) begin
			case (c)
				0: chanCond[c].paramErr = 1'b1;
				1: chanCond[c].intrLost = 1'b1;
				2: chanCond[c].underRange = 1'b1;
				default: chanCond[c].overRange = 1'b1;
			endcase
			tick(1);
			expect_byte(SET_FULL, 5'(OFS_CHAN0 + c), fexp[c]);
			expect_byte(SET_FULL, OFS_GROUP, 8'(1 << c));
			expect_byte(SET_HEAD, OFS_SUMMARY, (c == 0) ? 8'h88 : 8'h08);
			chanCond[c] = '0;
		end
		tick(1);
		expect_byte(SET_FULL, OFS_GROUP, 8'h00);
	endtask

	task automatic t_openwire();
		for (int m = 0; m < 4; m++) begin
			chanCond[1].openWire = 1'b1;
			chanCond[1].mode = chan_mode_t'(m);
			tick(1);
			expect_byte(SET_FULL, 5'h09, (m >= 2) ? 8'h10 : 8'h00);
			expect_byte(SET_FULL, OFS_GROUP, (m >= 2) ? 8'h02 : 8'h00);
		end
		chanCond[1] = '0;
	endtask

	// margins of tens of cycles keep each capture well inside one microsecond
	task automatic t_stamp();
		sys_rst = 1'b1;
		tick(2);
		sys_rst = 1'b0;
		expect_stamp(32'h0);
		tick(340);
		commErr = 1'b1;
		tick(1);
		chk("event", 32'h1, {31'h0, diagEvent});
		tick(1);
		chk("event drop", 32'h0, {31'h0, diagEvent});
		expect_stamp(32'h3);
		tick(390);
		intrLostAny = 1'b1;
		tick(1);
		chk("event", 32'h1, {31'h0, diagEvent});
		expect_stamp(32'h7);
		commErr = 1'b0;
		intrLostAny = 1'b0;
	endtask

	initial begin
		sys_rst = 1'b1;
		commErr = 1'b0;
		intrLostAny = 1'b0;
		for (int c = 0; c < 4; c++) chanCond[c] = '0;
		repeat (16) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		t_constants();
		t_refuse();
		t_sysflags();
		t_channels();
		t_openwire();
		t_stamp();
		give_verdict();
	end

	initial begin
		#200000;
		miscompares++;
		give_verdict();
	end
endmodule
`default_nettype wire
